/* File: sbm_checker.sv */
// sbm_checker.sv: concurrent checks on the register map's core-side ports.
// assumes: bound into sfr_bank_map; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sbm_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // core access
    input wire logic [6:0] accAddr,
    input wire logic rdEn,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic aluFlagWe,
    input wire logic [2:0] aluFlags,
    input wire logic [7:0] rdData,
    // program counter and events
    input wire logic pcJump,
    input wire logic [10:0] pcTarget,
    input wire logic [12:0] pcValue,
    input wire logic clrwdtExec,
    input wire logic sleepExec,
    input wire logic [2:0] intFlagSet,
    // register state
    input wire logic [7:0] statusValue,
    input wire logic [7:0] irqCtrlValue,
    input wire logic [7:0] portDirA
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_unimpl_reads_zero: assert property (
        rdEn && $past(reset_n) && statusValue[5] && accAddr inside {7'h0f, 7'h15, 7'h1a}
        |=> rdData == 8'h00) else $error("unimplemented location read nonzero");
    a_status_mirror: assert property (
        rdEn && !wrEn && $past(reset_n) && accAddr == 7'h03
        |=> rdData == $past(statusValue)) else $error("status read differs from register");
    a_jump_loads: assert property (
        pcJump && !wrEn && $past(reset_n) |=> pcValue[10:0] == $past(pcTarget))
        else $error("jump did not load its target");
    a_latch_to_pc: assert property (
        wrEn && accAddr == 7'h0a && $past(reset_n) ##1 !wrEn ##1 wrEn && accAddr == 7'h02
        |=> pcValue == {$past(wrData[4:0], 3), $past(wrData)})
        else $error("counter load missed the holding latch");
    a_status_guard: assert property (
        wrEn && accAddr == 7'h03 && !clrwdtExec && !sleepExec && $past(reset_n)
        |=> statusValue[4:3] == $past(statusValue[4:3])) else $error("timeout bits written");
    a_alu_wins: assert property (
        wrEn && aluFlagWe && accAddr == 7'h03 && $past(reset_n)
        |=> statusValue[2:0] == $past(aluFlags)) else $error("flag write not blocked");
    a_irq_flag_set: assert property (
        intFlagSet != 3'h0 && $past(reset_n)
        |=> (irqCtrlValue[2:0] & $past(intFlagSet)) == $past(intFlagSet))
        else $error("interrupt flag not set by its event");
    a_reset_values: assert property (
        !$past(reset_n) |-> portDirA == 8'h3f && pcValue == 13'h0000)
        else $error("reset values wrong at release");
endmodule // sbm_checker
bind sfr_bank_map sbm_checker u_chk (
    .mclk(mclk), .reset_n(reset_n), .accAddr(accAddr), .rdEn(rdEn), .wrEn(wrEn),
    .wrData(wrData), .aluFlagWe(aluFlagWe), .aluFlags(aluFlags), .rdData(rdData),
    .pcJump(pcJump), .pcTarget(pcTarget), .pcValue(pcValue), .clrwdtExec(clrwdtExec),
    .sleepExec(sleepExec), .intFlagSet(intFlagSet), .statusValue(statusValue),
    .irqCtrlValue(irqCtrlValue), .portDirA(portDirA));
`default_nettype wire

/* File: sbm_core_model.sv */
// sbm_core_model.sv: behavioural core data-memory path driving the register map.
// assumes: each call launches one request on a falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module sbm_core_model (
    // clock
    input wire logic mclk,
    // access toward the register map
    output logic [6:0] accAddr,
    output logic rdEn,
    output logic wrEn,
    output logic [7:0] wrData,
    output logic aluFlagWe,
    output logic [2:0] aluFlags,
    input wire logic [7:0] rdData
);
    initial begin
        {rdEn, wrEn, aluFlagWe} = 3'h0;
        accAddr = 7'h00;
        wrData = 8'h00;
        aluFlags = 3'h0;
    end
    // request stands over one rising edge; read data is taken one cycle later
    task automatic acc(input logic [6:0] a, input logic [7:0] d, input logic w,
                       input logic alu, output logic [7:0] q);
        @(negedge mclk);
        accAddr = a;
        wrEn = w;
        rdEn = ~w;
        wrData = d;
        if (a == 7'h03) wrData[7:6] = 2'b00;
        if (a == 7'h0c) wrData[7] = 1'b0;
        aluFlagWe = alu;
        aluFlags = 3'h4;
        @(negedge mclk);
        q = rdData;
        {rdEn, wrEn, aluFlagWe} = 3'h0;
        // released lines flip so stale values are never mistaken for live ones
        accAddr = ~accAddr;
        wrData = ~wrData;
    endtask
endmodule // sbm_core_model
`default_nettype wire

/* File: sbm_defines.vh */
// sbm_defines.vh: file addresses, reset values and bit masks of the register map.
// assumes: the includer compares against full 8-bit file addresses, bit 7 = bank.
`ifndef SBM_DEFINES_VH
`define SBM_DEFINES_VH
`define SBM_BANK_BIT 8'h80
`define SBM_INDIRECT_DATA_PORT 8'h00
`define SBM_TIMER0_COUNT 8'h01
`define SBM_PC_LOW_BYTE 8'h02
`define SBM_CORE_STATUS 8'h03
`define SBM_INDIRECT_POINTER 8'h04
`define SBM_PORT_A_PINS 8'h05
`define SBM_PORT_B_PINS 8'h06
`define SBM_PORT_C_PINS 8'h07
`define SBM_PORT_D_PINS 8'h08
`define SBM_PORT_E_PINS 8'h09
`define SBM_PC_HIGH_LATCH 8'h0a
`define SBM_CORE_IRQ_CTRL 8'h0b
`define SBM_PERIPH_FLAGS_1 8'h0c
`define SBM_PERIPH_FLAGS_2 8'h0d
`define SBM_TIMER1_LOW 8'h0e
`define SBM_TIMER1_HIGH 8'h0f
`define SBM_TIMER1_CTRL 8'h10
`define SBM_TIMER2_COUNT 8'h11
`define SBM_TIMER2_CTRL 8'h12
`define SBM_SSER_BUF 8'h13
`define SBM_SSER_CTRL 8'h14
`define SBM_CCP1_LOW 8'h15
`define SBM_CCP1_HIGH 8'h16
`define SBM_CCP1_CTRL 8'h17
`define SBM_USART_RX_STAT 8'h18
`define SBM_USART_TX_DATA 8'h19
`define SBM_USART_RX_DATA 8'h1a
`define SBM_CCP2_LOW 8'h1b
`define SBM_CCP2_HIGH 8'h1c
`define SBM_CCP2_CTRL 8'h1d
`define SBM_ADC_RESULT 8'h1e
`define SBM_ADC_CTRL 8'h1f
`define SBM_PRESCALE_CFG 8'h81
`define SBM_PORT_A_DIR 8'h85
`define SBM_PORT_B_DIR 8'h86
`define SBM_PORT_C_DIR 8'h87
`define SBM_PORT_D_DIR 8'h88
`define SBM_PORT_E_DIR_PSP 8'h89
`define SBM_PERIPH_EN_1 8'h8c
`define SBM_PERIPH_EN_2 8'h8d
`define SBM_POWER_CONTROL 8'h8e
`define SBM_TIMER2_PERIOD 8'h92
`define SBM_SSER_SLAVE_ADDR 8'h93
`define SBM_SSER_STATE 8'h94
`define SBM_USART_TX_STAT 8'h98
`define SBM_BAUD_DIVISOR 8'h99
`define SBM_ADC_PIN_CFG 8'h9f
// general-purpose ram
`define SBM_GPR_BASE 8'h20
`define SBM_GPR_PER_BANK 8'h60
// reset values
`define SBM_RST_ZERO 8'h00
`define SBM_RST_ALL_ONES 8'hff
`define SBM_RST_TX_STAT 8'h02
`define SBM_RST_DIR_A 8'h3f
`define SBM_RST_DIR_E 8'h07
`define SBM_RST_STATUS_HI 3'h0
`define SBM_RST_TOPD 2'h3
`define SBM_RST_PC 13'h0000
`define SBM_RST_LATCH 5'h00
// implemented-bit masks and the port A keep mask
`define SBM_MASK_FULL 8'hff
`define SBM_MASK_6B 8'h3f
`define SBM_MASK_T2_CTRL 8'h7f
`define SBM_MASK_USART_STAT 8'hf7
`define SBM_MASK_ADC_CTRL 8'hfd
`define SBM_MASK_3B 8'h07
`define SBM_MASK_DIR_E_WR 8'h17
`define SBM_MASK_NO_PSP 8'h7f
`define SBM_MASK_BIT0 8'h01
`define SBM_MASK_PORT_A_KEEP 8'h10
`endif

/* File: sfr_bank_map.v */
// sfr_bank_map.v: two-bank special-function register map and data ram of the core.
// assumes: core presents one access per cycle on accAddr; reset cause levels are
// held stable by the reset controller until the first edge after reset_n rises.
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defines.vh"
module sfr_bank_map #(
    parameter HAS_PORT_DE = 1,
    parameter HAS_BOR = 1,
    parameter HAS_PSP = 1
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // reset cause, held through release
    input wire powerUpReset,
    input wire brownoutReset,
    input wire watchdogReset,
    input wire sleepAtReset,
    // core data access
    input wire [6:0] accAddr,
    input wire rdEn,
    input wire wrEn,
    input wire [7:0] wrData,
    input wire aluFlagWe,
    input wire [2:0] aluFlags,
    output reg [7:0] rdData,
    // program counter
    input wire pcStep,
    input wire pcJump,
    input wire [10:0] pcTarget,
    output reg [12:0] pcValue,
    // core events
    input wire clrwdtExec,
    input wire sleepExec,
    input wire [2:0] intFlagSet,
    input wire [7:0] periphFlagSet1,
    input wire periphFlagSet2,
    // ports
    input wire [7:0] portPinsA,
    input wire [7:0] portPinsB,
    input wire [7:0] portPinsC,
    input wire [7:0] portPinsD,
    input wire [7:0] portPinsE,
    output reg [7:0] portLatchA,
    output reg [7:0] portLatchB,
    output reg [7:0] portLatchC,
    output reg [7:0] portLatchD,
    output reg [7:0] portLatchE,
    output reg [7:0] portDirA,
    output reg [7:0] portDirB,
    output reg [7:0] portDirC,
    output reg [7:0] portDirD,
    output reg [7:0] portDirE,
    input wire [2:0] pspStatus,
    // peripheral data
    input wire [7:0] adcResult,
    input wire [7:0] usartRxData,
    // register state toward the core and peripherals
    output wire [7:0] statusValue,
    output wire [7:0] irqCtrlValue,
    output reg [7:0] periphFlags1,
    output reg [7:0] periphEnables1,
    output reg periphFlags2,
    output reg periphEnables2,
    output reg sfrWrStrobe,
    output reg [7:0] sfrWrAddr,
    output reg [7:0] sfrWrData
);

    function [7:0] genMask;
        input [7:0] a;
        begin
            case (a)
                `SBM_TIMER0_COUNT, `SBM_TIMER1_LOW, `SBM_TIMER1_HIGH,
                `SBM_TIMER2_COUNT, `SBM_SSER_BUF, `SBM_SSER_CTRL,
                `SBM_CCP1_LOW, `SBM_CCP1_HIGH, `SBM_USART_TX_DATA,
                `SBM_CCP2_LOW, `SBM_CCP2_HIGH, `SBM_PRESCALE_CFG,
                `SBM_TIMER2_PERIOD, `SBM_SSER_SLAVE_ADDR,
                `SBM_BAUD_DIVISOR: genMask = `SBM_MASK_FULL;
                `SBM_TIMER1_CTRL, `SBM_CCP1_CTRL, `SBM_CCP2_CTRL,
                `SBM_SSER_STATE: genMask = `SBM_MASK_6B;
                `SBM_TIMER2_CTRL: genMask = `SBM_MASK_T2_CTRL;
                `SBM_USART_RX_STAT,
                `SBM_USART_TX_STAT: genMask = `SBM_MASK_USART_STAT;
                `SBM_ADC_CTRL: genMask = `SBM_MASK_ADC_CTRL;
                `SBM_ADC_PIN_CFG: genMask = `SBM_MASK_3B;
                default: genMask = `SBM_RST_ZERO;
            endcase
        end
    endfunction

    function [7:0] genRst;
        input [7:0] a;
        begin
            case (a)
                `SBM_PRESCALE_CFG, `SBM_TIMER2_PERIOD: genRst = `SBM_RST_ALL_ONES;
                `SBM_USART_TX_STAT: genRst = `SBM_RST_TX_STAT;
                default: genRst = `SBM_RST_ZERO;
            endcase
        end
    endfunction

    // registers that hold their value over a pin or watchdog reset
    function genKeep;
        input [7:0] a;
        begin
            case (a)
                `SBM_TIMER0_COUNT, `SBM_TIMER1_LOW, `SBM_TIMER1_HIGH,
                `SBM_TIMER1_CTRL, `SBM_SSER_BUF, `SBM_CCP1_LOW,
                `SBM_CCP1_HIGH, `SBM_CCP2_LOW, `SBM_CCP2_HIGH: genKeep = 1'b1;
                default: genKeep = 1'b0;
            endcase
        end
    endfunction

    // pins read back through the implemented-bit mask; absent ports read zero
    function [7:0] portRead;
        input [7:0] pins;
        input [7:0] mask;
        input present;
        begin
            if (present)
                portRead = pins & mask;
            else
                portRead = `SBM_RST_ZERO;
        end
    endfunction

    // core registers decode the same in both banks
    function isCore;
        input [7:0] a;
        begin
            case (a & ~`SBM_BANK_BIT)
                `SBM_PC_LOW_BYTE, `SBM_CORE_STATUS, `SBM_INDIRECT_POINTER,
                `SBM_PC_HIGH_LATCH, `SBM_CORE_IRQ_CTRL: isCore = 1'b1;
                default: isCore = 1'b0;
            endcase
        end
    endfunction

    // timeout and powerdown after reset; a pin reset out of sleep sets timeout and clears powerdown
    function [1:0] resetToPd;
        input power;
        input wdt;
        input asleep;
        begin
            if (power)
                resetToPd = `SBM_RST_TOPD;
            else
                resetToPd = {~wdt, ~asleep};
        end
    endfunction

    function [7:0] gprIndex;
        input [7:0] a;
        begin
            gprIndex = {1'b0, a[6:0]} - `SBM_GPR_BASE;
            if (a[7])
                gprIndex = gprIndex + `SBM_GPR_PER_BANK;
        end
    endfunction

    integer i;
    reg [7:0] genReg [0:63];
    // bank 1 ram follows bank 0 ram in one array
    reg [7:0] gpr [0:191];
    reg rstApply_q;
    reg [2:0] statusHi_q;
    reg [1:0] toPd_q;
    reg [2:0] flags_q;
    reg [7:0] ptr_q;
    reg [4:0] pcLatch_q;
    reg [6:0] irqHi_q;
    reg irqLow_q;
    reg [1:0] power_control_q;
    reg [7:0] rdMux;

    wire hasDE = (HAS_PORT_DE != 0);
    wire [7:0] pir1Mask = (HAS_PSP != 0) ? `SBM_MASK_FULL : `SBM_MASK_NO_PSP;
    wire [7:0] pconMask = (HAS_BOR != 0) ? `SBM_MASK_3B : 8'h02;
    wire indirect = ({1'b0, accAddr} == `SBM_INDIRECT_DATA_PORT);
    wire [7:0] eff = indirect ? ptr_q : {statusHi_q[0], accAddr};
    wire isGpr = (eff[6:5] != 2'b00);
    wire isSelf = ({1'b0, eff[6:0]} == `SBM_INDIRECT_DATA_PORT);
    wire [5:0] genIdx = {eff[7], eff[4:0]};
    wire [7:0] gIdx = gprIndex(eff);
    // the apply cycle drops accesses so a write cannot race the reset load
    // a pointer of 00h or 80h would address itself, so such writes are refused
    wire wrOk = wrEn & ~rstApply_q & ~isSelf;
    wire wrSfr = wrOk & ~isGpr;
    wire [7:0] effCore = eff & ~`SBM_BANK_BIT;
    wire coreHit = isCore(eff);
    wire wrPcl = wrSfr && (effCore == `SBM_PC_LOW_BYTE);
    wire wrStatus = wrSfr && (effCore == `SBM_CORE_STATUS);
    wire wrIrq = wrSfr && (effCore == `SBM_CORE_IRQ_CTRL);

    assign statusValue = {statusHi_q, toPd_q, flags_q};
    assign irqCtrlValue = {irqHi_q, irqLow_q};

    // read decode; core registers ignore the bank bit
    always @* begin
        rdMux = `SBM_RST_ZERO;
        if (isGpr)
            rdMux = gpr[gIdx];
        else if (isSelf)
            rdMux = `SBM_RST_ZERO;
        else if (coreHit) begin
            case (effCore)
                `SBM_PC_LOW_BYTE: rdMux = pcValue[7:0];
                `SBM_CORE_STATUS: rdMux = statusValue;
                `SBM_INDIRECT_POINTER: rdMux = ptr_q;
                `SBM_PC_HIGH_LATCH: rdMux = {3'b000, pcLatch_q};
                default: rdMux = irqCtrlValue;
            endcase
        end else begin
            case (eff)
                `SBM_PORT_A_PINS: rdMux = portRead(portPinsA, `SBM_MASK_6B, 1'b1);
                `SBM_PORT_B_PINS: rdMux = portRead(portPinsB, `SBM_MASK_FULL, 1'b1);
                `SBM_PORT_C_PINS: rdMux = portRead(portPinsC, `SBM_MASK_FULL, 1'b1);
                `SBM_PORT_D_PINS: rdMux = portRead(portPinsD, `SBM_MASK_FULL, hasDE);
                `SBM_PORT_E_PINS: rdMux = portRead(portPinsE, `SBM_MASK_3B, hasDE);
                `SBM_PORT_A_DIR: rdMux = portDirA;
                `SBM_PORT_B_DIR: rdMux = portDirB;
                `SBM_PORT_C_DIR: rdMux = portDirC;
                `SBM_PORT_D_DIR: rdMux = hasDE ? portDirD : `SBM_RST_ZERO;
                `SBM_PORT_E_DIR_PSP: rdMux = hasDE ? ({pspStatus, 5'h00} | portDirE) : `SBM_RST_ZERO;
                `SBM_PERIPH_FLAGS_1: rdMux = periphFlags1;
                `SBM_PERIPH_FLAGS_2: rdMux = {7'h00, periphFlags2};
                `SBM_PERIPH_EN_1: rdMux = periphEnables1;
                `SBM_PERIPH_EN_2: rdMux = {7'h00, periphEnables2};
                `SBM_POWER_CONTROL: rdMux = {6'h00, power_control_q} & pconMask;
                `SBM_USART_RX_DATA: rdMux = usartRxData;
                `SBM_ADC_RESULT: rdMux = adcResult;
                default: rdMux = genReg[genIdx] & genMask(eff);
            endcase
        end
    end

    // state whose reset value does not depend on the reset cause
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstApply_q <= 1'b1;
            statusHi_q <= `SBM_RST_STATUS_HI;
            pcValue <= `SBM_RST_PC;
            pcLatch_q <= `SBM_RST_LATCH;
            irqHi_q <= 7'h00;
            periphFlags1 <= `SBM_RST_ZERO;
            periphFlags2 <= 1'b0;
            periphEnables1 <= `SBM_RST_ZERO;
            periphEnables2 <= 1'b0;
            portDirA <= `SBM_RST_DIR_A;
            portDirB <= `SBM_RST_ALL_ONES;
            portDirC <= `SBM_RST_ALL_ONES;
            portDirD <= `SBM_RST_ALL_ONES;
            portDirE <= `SBM_RST_DIR_E;
            rdData <= `SBM_RST_ZERO;
            sfrWrStrobe <= 1'b0;
            sfrWrAddr <= `SBM_RST_ZERO;
            sfrWrData <= `SBM_RST_ZERO;
        end else begin
            rstApply_q <= 1'b0;
            // read data stands until the next read is taken
            if (rdEn && !rstApply_q)
                rdData <= rdMux;
            sfrWrStrobe <= wrSfr;
            if (wrSfr) begin
                sfrWrAddr <= eff;
                sfrWrData <= wrData;
            end
            if (wrStatus)
                statusHi_q <= wrData[7:5];
            // low-byte writes take all five upper bits from the latch
            if (wrPcl)
                pcValue <= {pcLatch_q, wrData};
            else if (pcJump)
                // a jump carries 11 bits, so only the top two come from the latch
                pcValue <= {pcLatch_q[4:3], pcTarget};
            else if (pcStep)
                pcValue <= pcValue + 13'd1;
            if (wrSfr && effCore == `SBM_PC_HIGH_LATCH)
                pcLatch_q <= wrData[4:0];
            if (wrIrq)
                irqHi_q[6:2] <= wrData[7:3];
            // hardware set wins over a clearing write
            irqHi_q[1:0] <= (wrIrq ? wrData[2:1] : irqHi_q[1:0]) | intFlagSet[2:1];
            periphFlags1 <= (((wrSfr && eff == `SBM_PERIPH_FLAGS_1) ? wrData : periphFlags1)
                            | periphFlagSet1) & pir1Mask;
            periphFlags2 <= ((wrSfr && eff == `SBM_PERIPH_FLAGS_2) ? wrData[0] : periphFlags2)
                            | periphFlagSet2;
            if (wrSfr && eff == `SBM_PERIPH_EN_1)
                periphEnables1 <= wrData & pir1Mask;
            if (wrSfr && eff == `SBM_PERIPH_EN_2)
                periphEnables2 <= wrData[0];
            if (wrSfr && eff == `SBM_PORT_A_DIR)
                portDirA <= wrData & `SBM_MASK_6B;
            if (wrSfr && eff == `SBM_PORT_B_DIR)
                portDirB <= wrData;
            if (wrSfr && eff == `SBM_PORT_C_DIR)
                portDirC <= wrData;
            if (wrSfr && eff == `SBM_PORT_D_DIR && hasDE)
                portDirD <= wrData;
            if (wrSfr && eff == `SBM_PORT_E_DIR_PSP && hasDE)
                portDirE <= wrData & `SBM_MASK_DIR_E_WR;
        end
    end

    // cause-dependent state, loaded at the first edge after reset release
    always @(posedge mclk) begin
        if (rstApply_q) begin
            // kept registers skip the load on a pin or watchdog reset
            for (i = 0; i < 64; i = i + 1) begin
                if (powerUpReset || !genKeep({i[5], 2'b00, i[4:0]}))
                    genReg[i] <= genRst({i[5], 2'b00, i[4:0]});
            end
            toPd_q <= resetToPd(powerUpReset, watchdogReset, sleepAtReset);
            if (powerUpReset) begin
                flags_q <= 3'b000;
                ptr_q <= `SBM_RST_ZERO;
                irqLow_q <= 1'b0;
                portLatchA <= `SBM_RST_ZERO;
                portLatchB <= `SBM_RST_ZERO;
                portLatchC <= `SBM_RST_ZERO;
                portLatchD <= `SBM_RST_ZERO;
                portLatchE <= `SBM_RST_ZERO;
                power_control_q <= brownoutReset ? 2'b10 : 2'b00;
            end else begin
                portLatchA <= portLatchA & `SBM_MASK_PORT_A_KEEP;
            end
        end else begin
            if (clrwdtExec || sleepExec)
                toPd_q <= {1'b1, ~sleepExec};
            if (aluFlagWe)
                flags_q <= aluFlags;
            else if (wrStatus)
                flags_q <= wrData[2:0];
            irqLow_q <= (wrIrq ? wrData[0] : irqLow_q) | intFlagSet[0];
            if (wrSfr && effCore == `SBM_INDIRECT_POINTER)
                ptr_q <= wrData;
            if (wrSfr && eff == `SBM_PORT_A_PINS)
                portLatchA <= wrData & `SBM_MASK_6B;
            if (wrSfr && eff == `SBM_PORT_B_PINS)
                portLatchB <= wrData;
            if (wrSfr && eff == `SBM_PORT_C_PINS)
                portLatchC <= wrData;
            if (wrSfr && eff == `SBM_PORT_D_PINS && hasDE)
                portLatchD <= wrData;
            if (wrSfr && eff == `SBM_PORT_E_PINS && hasDE)
                portLatchE <= wrData & `SBM_MASK_3B;
            if (wrSfr && eff == `SBM_POWER_CONTROL)
                power_control_q <= wrData[1:0] & pconMask[1:0];
            if (wrSfr && eff[6:5] == 2'b00)
                genReg[genIdx] <= wrData & genMask(eff);
            if (wrOk && isGpr)
                gpr[gIdx] <= wrData;
        end
    end

endmodule // sfr_bank_map
`default_nettype wire

/* File: test_sfr_bank_map.sv */
// test_sfr_bank_map.sv: register-level regression of the two-bank register map.
// assumes: the core model issues every access; a pin reads latch xor direction.
`timescale 1ns/1ps
`default_nettype none
module test_sfr_bank_map;
    logic mclk, reset_n, powerUpReset, brownoutReset, watchdogReset;
    logic rdEn, wrEn, aluFlagWe, pcStep, pcJump, clrwdtExec, sleepExec, periphFlagSet2;
    logic [6:0] accAddr;
    logic [2:0] aluFlags, intFlagSet;
    logic [7:0] wrData, rdData, periphFlagSet1, statusValue, irqCtrlValue, periphFlags1, q;
    logic [10:0] pcTarget;
    logic [12:0] pcValue;
    logic sfrWrStrobe, sleepAtReset;
    logic [7:0] sfrWrAddr, sfrWrData, periphEnables1;
    logic periphFlags2;
    wire [7:0] lat [5];
    wire [7:0] dir [5];
    logic [7:0] pin [5];
    int miscompares = 0;
    int samples_checked = 0;
    logic [15:0] porTab [$] = '{16'h0200, 16'h0a00, 16'h0c00, 16'h0d00, 16'h1000, 16'h1100,
        16'h1200, 16'h1400, 16'h1700, 16'h1900, 16'h1a3e, 16'h1e9c, 16'h1f00, 16'h0318,
        16'h81ff, 16'h853f, 16'h86ff, 16'h87ff, 16'h88ff, 16'h89a7, 16'h8c00, 16'h8d00,
        16'h8e00, 16'h92ff, 16'h9802, 16'h9f00, 16'h8338};
    logic [23:0] wrTab [$] = '{24'h8fff00, 24'h95ff00, 24'h9aff00, 24'h85ff3f, 24'h89ffb7,
        24'h8cff7f, 24'h12ff7f, 24'h1ffffd, 24'h0dff01, 24'h0cff7f, 24'h1aff3e};
    logic [15:0] preTab [$] = '{16'h0477, 16'h0e5c, 16'h1144, 16'h8100, 16'h063c, 16'h0a1f};
    logic [15:0] keepTab [$] = '{16'h0477, 16'h0e5c, 16'h1100, 16'h81ff, 16'h8e02, 16'h0a00};
    always_comb foreach (pin[i]) pin[i] = lat[i] ^ dir[i];
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    sbm_core_model u_core (.mclk(mclk), .accAddr(accAddr), .rdEn(rdEn), .wrEn(wrEn),
        .wrData(wrData), .aluFlagWe(aluFlagWe), .aluFlags(aluFlags), .rdData(rdData));
    sfr_bank_map u_dut (
        .mclk(mclk), .reset_n(reset_n), .powerUpReset(powerUpReset),
        .brownoutReset(brownoutReset), .watchdogReset(watchdogReset), .sleepAtReset(sleepAtReset),
        .accAddr(accAddr), .rdEn(rdEn), .wrEn(wrEn), .wrData(wrData), .aluFlagWe(aluFlagWe),
        .aluFlags(aluFlags), .rdData(rdData), .pcStep(pcStep), .pcJump(pcJump),
        .pcTarget(pcTarget), .pcValue(pcValue), .clrwdtExec(clrwdtExec), .sleepExec(sleepExec),
        .intFlagSet(intFlagSet), .periphFlagSet1(periphFlagSet1),
        .periphFlagSet2(periphFlagSet2), .portPinsA(pin[0]), .portPinsB(pin[1]),
        .portPinsC(pin[2]), .portPinsD(pin[3]), .portPinsE(pin[4]), .portLatchA(lat[0]),
        .portLatchB(lat[1]), .portLatchC(lat[2]), .portLatchD(lat[3]), .portLatchE(lat[4]),
        .portDirA(dir[0]), .portDirB(dir[1]), .portDirC(dir[2]), .portDirD(dir[3]),
        .portDirE(dir[4]), .pspStatus(3'h5), .adcResult(8'h9c), .usartRxData(8'h3e),
        .statusValue(statusValue), .irqCtrlValue(irqCtrlValue), .periphFlags1(periphFlags1),
        .periphEnables1(periphEnables1), .periphFlags2(periphFlags2), .periphEnables2(),
        .sfrWrStrobe(sfrWrStrobe), .sfrWrAddr(sfrWrAddr), .sfrWrData(sfrWrData));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // bank switch rewrites status and so clears its three arithmetic flags
    task automatic bank(input logic b);
        if (statusValue[5] !== b) u_core.acc(7'h03, {2'b00, b, 5'h00}, 1'b1, 1'b0, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bank(a[7]);
        u_core.acc(a[6:0], d, 1'b1, 1'b0, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bank(a[7]);
        u_core.acc(a[6:0], 8'h00, 1'b0, 1'b0, q);
        chk($sformatf("register %h", a), e, q);
    endtask
    task automatic doReset(input logic pu, input logic bo, input logic wd);
        @(negedge mclk);
        reset_n = 1'b0;
        powerUpReset = pu;
        brownoutReset = bo;
        watchdogReset = wd;
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        repeat (2) @(negedge mclk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {reset_n, powerUpReset, brownoutReset, watchdogReset, sleepAtReset} = 5'h00;
        {pcStep, pcJump, clrwdtExec, sleepExec, periphFlagSet2} = 5'h00;
        pcTarget = 11'h000;
        intFlagSet = 3'h0;
        periphFlagSet1 = 8'h00;
        doReset(1'b1, 1'b0, 1'b0);
        foreach (porTab[i]) rd(porTab[i][15:8], porTab[i][7:0]);
        foreach (wrTab[i]) begin
            wr(wrTab[i][23:16], wrTab[i][15:8]);
            rd(wrTab[i][23:16], wrTab[i][7:0]);
        end
        chk("enables 1", 8'h7f, periphEnables1);
        wr(8'h8a, 8'h0b);
        wr(8'h02, 8'h34);
        chk("pc high", 8'h0b, {3'h0, pcValue[12:8]});
        wr(8'h0a, 8'h0b);
        wr(8'h02, 8'h34);
        chk("pc low", 8'h34, pcValue[7:0]);
        @(negedge mclk);
        pcTarget = 11'h123;
        pcJump = 1'b1;
        @(negedge mclk);
        pcJump = 1'b0;
        pcStep = 1'b1;
        chk("jump high", 8'h09, {3'h0, pcValue[12:8]});
        @(negedge mclk);
        pcStep = 1'b0;
        chk("step low", 8'h24, pcValue[7:0]);
        wr(8'h04, 8'h20);
        wr(8'h00, 8'h5a);
        rd(8'h20, 8'h5a);
        wr(8'h04, 8'ha0);
        wr(8'h00, 8'hc3);
        rd(8'ha0, 8'hc3);
        wr(8'h04, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h06, 8'h55);
        chk("latch b", 8'h55, lat[1]);
        chk("write data", 8'h55, sfrWrData);
        rd(8'h06, 8'haa);
        wr(8'h86, 8'h00);
        chk("write addr", 8'h86, sfrWrStrobe ? sfrWrAddr : 8'h00);
        rd(8'h06, 8'h55);
        wr(8'h0c, 8'h00);
        wr(8'h0d, 8'h00);
        u_core.acc(7'h03, 8'h00, 1'b1, 1'b1, q);
        chk("status alu", 8'h1c, statusValue);
        u_core.acc(7'h03, 8'hff, 1'b1, 1'b0, q);
        chk("status plain", 8'h3f, statusValue);
        @(negedge mclk);
        {sleepExec, periphFlagSet2} = 2'b11;
        intFlagSet = 3'h7;
        periphFlagSet1 = 8'h42;
        @(negedge mclk);
        {sleepExec, periphFlagSet2, clrwdtExec} = 3'b001;
        intFlagSet = 3'h0;
        periphFlagSet1 = 8'h00;
        chk("status sleep", 8'h37, statusValue);
        chk("irq flags", 8'h07, {5'h00, irqCtrlValue[2:0]});
        chk("periph flags", 8'h42, periphFlags1);
        chk("periph flag 2", 8'h01, {7'h00, periphFlags2});
        @(negedge mclk);
        clrwdtExec = 1'b0;
        chk("status clear", 8'h3f, statusValue);
        doReset(1'b1, 1'b1, 1'b0);
        rd(8'h8e, 8'h02);
        foreach (preTab[i]) wr(preTab[i][15:8], preTab[i][7:0]);
        doReset(1'b0, 1'b0, 1'b1);
        chk("status cause", 8'h08, statusValue & 8'hf8);
        chk("latch kept", 8'h3c, lat[1]);
        foreach (keepTab[i]) rd(keepTab[i][15:8], keepTab[i][7:0]);
        sleepAtReset = 1'b1;
        doReset(1'b0, 1'b0, 1'b0);
        chk("status sleep cause", 8'h10, statusValue & 8'hf8);
        summarize();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        summarize();
    end
endmodule // test_sfr_bank_map
`default_nettype wire
